// *** rtl/fsr_map.svh ***
// offsets, field positions, reset values and timing counts of the
// floppy status register bank; assumes a 50 MHz system clock
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FSR_ADR_COND 8'h00
`define FSR_ADR_CMD 8'h04
`define FSR_ADR_DATA 8'h08
`define FSR_ADR_IRQ_STAT 8'h0C
`define FSR_ADR_IRQ_MASK 8'h10
`define FSR_ADR_CTRL 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FSR_IRQ_DONE 0
`define FSR_IRQ_DATA 1
`define FSR_IRQ_ERR 2
`define FSR_IRQ_W 3
`define FSR_CTRL_WIDE 0
`define FSR_CTRL_SLOW 1
`define FSR_CTRL_MFM 2
`define FSR_CTRL_W 3
`define FSR_CMD_W 3
`define FSR_CMD_BAD 3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FSR_MASK_RST 3'h0
`define FSR_CTRL_RST 3'h0
`define FSR_DATA_RST 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSR_CLK_MHZ 50
`define FSR_T_DIR_US 12
`define FSR_T_STEP_NARROW_US 2
`define FSR_T_STEP_WIDE_US 4
`define FSR_T_SPAN_MFM_NS 300
`define FSR_T_SPAN_FM_NS 600
`define FSR_DIR_CYC (`FSR_T_DIR_US * `FSR_CLK_MHZ)
`define FSR_STEP_N_CYC (`FSR_T_STEP_NARROW_US * `FSR_CLK_MHZ)
`define FSR_STEP_W_CYC (`FSR_T_STEP_WIDE_US * `FSR_CLK_MHZ)
`define FSR_SPAN_MFM_CYC ((`FSR_T_SPAN_MFM_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_SPAN_FM_CYC ((`FSR_T_SPAN_FM_NS * `FSR_CLK_MHZ) / 1000)

`endif

// *** rtl/fsr_pkg.sv ***
// types shared by the floppy status register bank
// assumes nothing beyond a SystemVerilog compiler
package fsr_pkg;

  // command class that selects the status bit sources
  typedef enum logic [2:0] {
    FSR_CMD_TYPE1 = 3'h0,
    FSR_CMD_RD_ADDR = 3'h1,
    FSR_CMD_RD_SECT = 3'h2,
    FSR_CMD_RD_TRACK = 3'h3,
    FSR_CMD_WR_SECT = 3'h4,
    FSR_CMD_WR_TRACK = 3'h5,
    FSR_CMD_FORCE = 3'h6
  } fsr_cmd_t;

  typedef enum logic [1:0] {
    FSR_ST_IDLE = 2'h0,
    FSR_ST_SETUP = 2'h1,
    FSR_ST_PULSE = 2'h2
  } fsr_step_st_t;

endpackage : fsr_pkg

// *** rtl/fsr_step_timer.sv ***
// step and direction output timing for the head positioner
// assumes one 50 MHz clock and a one-cycle step request
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.svh"

module fsr_step_timer #(
  parameter int CW = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic dir_i,
  input wire logic wide_i,
  input wire logic slow_i,
  output logic step_o,
  output logic dir_o,
  output logic busy_o
);

  fsr_pkg::fsr_step_st_t state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] setup_cyc;
  logic [CW-1:0] pulse_cyc;

  // 1 MHz master clock mode doubles every duration
  assign setup_cyc = CW'(slow_i ? 2 * `FSR_DIR_CYC : `FSR_DIR_CYC);
  assign pulse_cyc = CW'(wide_i ? (slow_i ? 2 * `FSR_STEP_W_CYC : `FSR_STEP_W_CYC)
                                : (slow_i ? 2 * `FSR_STEP_N_CYC : `FSR_STEP_N_CYC));
  assign busy_o = state != fsr_pkg::FSR_ST_IDLE;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= fsr_pkg::FSR_ST_IDLE;
      cnt <= '0;
      step_o <= 1'b0;
      dir_o <= 1'b0;
    end
    else
    begin
      case (state)
        fsr_pkg::FSR_ST_IDLE:
        begin
          if (req_i)
          begin
            dir_o <= dir_i; // direction settles before the step
            cnt <= setup_cyc - CW'(1);
            state <= fsr_pkg::FSR_ST_SETUP;
          end
        end
        fsr_pkg::FSR_ST_SETUP:
        begin
          if (cnt == '0)
          begin
            step_o <= 1'b1; // step pulse 2 or 4 us
            cnt <= pulse_cyc - CW'(1);
            state <= fsr_pkg::FSR_ST_PULSE;
          end
          else
          begin
            cnt <= cnt - CW'(1);
          end
        end
        fsr_pkg::FSR_ST_PULSE:
        begin
          if (cnt == '0)
          begin
            step_o <= 1'b0;
            state <= fsr_pkg::FSR_ST_IDLE;
          end
          else
          begin
            cnt <= cnt - CW'(1);
          end
        end
        default:
        begin
          step_o <= 1'b0;
          state <= fsr_pkg::FSR_ST_IDLE;
        end
      endcase
    end
  end

endmodule : fsr_step_timer
`default_nettype wire

// *** rtl/fsr_top.sv ***
// floppy controller status register bank with wishbone slave
// assumes command engine events as one-cycle pulses, drive pins sampled
// synchronously to CLOCK_I, and the write protect, track zero and index pins active low
//
// Behaviour
// - bit 7 is not-ready or master reset
// - type I bit 6 is inverted write protect
// - type I bit 5 is head load AND timing
// - type I bit 4 seek error, cleared on update
// - type I bit 3 flags ID checksum error
// - type I bit 2 is inverted track zero
// - type I bit 1 is inverted index pulse
// - bit 0 busy while a command runs
// - read/write commands remap bits 4, 2, 1
// - per-command zeros, record type, write fault
// - step 2/4 us, direction 12 us before
// - spanning raw pulse under 300 ns MFM
// - read window polarity does not matter
// - new non-force command sets busy, clears other bits
// - status read clears interrupt; data access clears request
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.svh"

module fsr_top #(
  parameter int WCW = 7
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ_O,
  input wire logic MASTER_RESET_IN_I,
  input wire logic READY_I,
  input wire logic WRITE_PROTECT_IN_I,
  input wire logic HEAD_LOAD_OUT_I,
  input wire logic HEAD_LOAD_TIMING_IN_I,
  input wire logic TRACK_ZERO_IN_I,
  input wire logic INDEX_PULSE_IN_I,
  input wire logic SEEK_ERR_I,
  input wire logic CRC_ERR_I,
  input wire logic RECORD_NOT_FOUND_I,
  input wire logic LOST_DATA_I,
  input wire logic WRITE_FAULT_I,
  input wire logic DELETED_MARK_I,
  input wire logic DATA_REQUEST_SET_I,
  input wire logic [7:0] DATA_BYTE_I,
  input wire logic DONE_I,
  input wire logic STEP_REQ_I,
  input wire logic STEP_DIR_I,
  input wire logic RAW_READ_I,
  input wire logic READ_WINDOW_I,
  output logic [7:0] DATA_BYTE_O,
  output logic [2:0] CMD_TYPE_O,
  output logic DATA_REQUEST_O,
  output logic INTERRUPT_REQUEST_O,
  output logic STEP_O,
  output logic DIR_O,
  output logic STEP_BUSY_O,
  output logic RAW_PULSE_O,
  output logic RAW_WINDOW_O,
  output logic RAW_REJECT_O
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic rd;
  logic wr;
  logic hit_cond;
  logic hit_cmd;
  logic hit_data;
  logic hit_stat;
  logic hit_mask;
  logic hit_ctrl;

  // ack lasts one cycle; the request is masked only while ack is high, so a held request is taken again
  assign req = CYC_I & STB_I & ~ACK_O;
  assign rd = req & ~WE_I;
  assign wr = req & WE_I & SEL_I[0];
  assign hit_cond = ADR_I == `FSR_ADR_COND;
  assign hit_cmd = ADR_I == `FSR_ADR_CMD;
  assign hit_data = ADR_I == `FSR_ADR_DATA;
  assign hit_stat = ADR_I == `FSR_ADR_IRQ_STAT;
  assign hit_mask = ADR_I == `FSR_ADR_IRQ_MASK;
  assign hit_ctrl = ADR_I == `FSR_ADR_CTRL;

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  fsr_pkg::fsr_cmd_t cmd_type;
  fsr_pkg::fsr_cmd_t new_type;
  logic busy;
  logic cmd_ok;
  logic is_force;
  logic clear_flags;

  assign new_type = fsr_pkg::fsr_cmd_t'(DAT_I[2:0]);
  assign cmd_ok = wr & hit_cmd & (DAT_I[2:0] != `FSR_CMD_BAD);
  assign is_force = new_type == fsr_pkg::FSR_CMD_FORCE;
  // force interrupt mid-command keeps the other bits
  assign clear_flags = cmd_ok & (~is_force | ~busy);
  assign CMD_TYPE_O = cmd_type;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      busy <= 1'b0;
    end
    else if (cmd_ok)
    begin
      busy <= ~is_force;
    end
    else if (DONE_I)
    begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cmd_type <= fsr_pkg::FSR_CMD_TYPE1;
    end
    else if (cmd_ok & ~is_force)
    begin
      cmd_type <= new_type;
    end
    else if (cmd_ok & ~busy)
    begin
      cmd_type <= fsr_pkg::FSR_CMD_TYPE1; // idle force shows type I
    end
  end

  // ----------------------------------------------------------------
  // sticky error flags
  // ----------------------------------------------------------------
  // order: seek, crc, not found, lost, write fault, deleted mark
  logic [5:0] flag_set;
  logic [5:0] flag;

  assign flag_set = {DELETED_MARK_I, WRITE_FAULT_I, LOST_DATA_I,
                     RECORD_NOT_FOUND_I, CRC_ERR_I, SEEK_ERR_I};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_flag
      // an event in the clearing cycle survives
      always_ff @(posedge CLOCK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          flag[gi] <= 1'b0;
        end
        else if (flag_set[gi])
        begin
          flag[gi] <= 1'b1;
        end
        else if (clear_flags)
        begin
          flag[gi] <= 1'b0; // reset when updated
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // data register and request lines
  // ----------------------------------------------------------------
  logic data_access;

  assign data_access = req & hit_data;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      DATA_BYTE_O <= `FSR_DATA_RST;
    end
    else if (DATA_REQUEST_SET_I)
    begin
      DATA_BYTE_O <= DATA_BYTE_I;
    end
    else if (wr & hit_data)
    begin
      DATA_BYTE_O <= DAT_I[7:0];
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      DATA_REQUEST_O <= 1'b0;
    end
    else if (DATA_REQUEST_SET_I)
    begin
      DATA_REQUEST_O <= 1'b1;
    end
    else if (data_access | clear_flags)
    begin
      DATA_REQUEST_O <= 1'b0; // read or write of data clears it
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      INTERRUPT_REQUEST_O <= 1'b0;
    end
    else if (DONE_I | (cmd_ok & is_force & busy))
    begin
      INTERRUPT_REQUEST_O <= 1'b1;
    end
    else if (rd & hit_cond)
    begin
      INTERRUPT_REQUEST_O <= 1'b0; // status read clears it
    end
  end

  // ----------------------------------------------------------------
  // status composition
  // ----------------------------------------------------------------
  logic [7:0] cond;
  logic not_ready;
  logic wp;

  assign not_ready = ~READY_I | MASTER_RESET_IN_I;
  assign wp = ~WRITE_PROTECT_IN_I;

  // sources follow the last accepted non-force command, or type I after a force while idle
  always_comb
  begin
    cond = 8'h00;
    cond[7] = not_ready;
    cond[0] = busy;
    case (cmd_type)
      fsr_pkg::FSR_CMD_TYPE1:
      begin
        cond[6] = wp;
        cond[5] = HEAD_LOAD_OUT_I & HEAD_LOAD_TIMING_IN_I;
        cond[4] = flag[0];
        cond[3] = flag[1];
        cond[2] = ~TRACK_ZERO_IN_I;
        cond[1] = ~INDEX_PULSE_IN_I;
      end
      fsr_pkg::FSR_CMD_RD_ADDR:
      begin
        cond[4:1] = {flag[2], flag[1], flag[3], DATA_REQUEST_O};
      end
      fsr_pkg::FSR_CMD_RD_SECT:
      begin
        cond[5] = flag[5];
        cond[4:1] = {flag[2], flag[1], flag[3], DATA_REQUEST_O};
      end
      fsr_pkg::FSR_CMD_RD_TRACK:
      begin
        cond[2:1] = {flag[3], DATA_REQUEST_O};
      end
      fsr_pkg::FSR_CMD_WR_SECT:
      begin
        cond[6:5] = {wp, flag[4]};
        cond[4:1] = {flag[2], flag[1], flag[3], DATA_REQUEST_O};
      end
      fsr_pkg::FSR_CMD_WR_TRACK:
      begin
        cond[6:5] = {wp, flag[4]};
        cond[2:1] = {flag[3], DATA_REQUEST_O};
      end
      default:
      begin
        cond[6:1] = 6'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [`FSR_IRQ_W-1:0] irq_stat;
  logic [`FSR_IRQ_W-1:0] irq_mask;
  logic [`FSR_IRQ_W-1:0] irq_ev;
  logic [`FSR_IRQ_W-1:0] irq_clr;

  assign irq_ev[`FSR_IRQ_DONE] = DONE_I;
  assign irq_ev[`FSR_IRQ_DATA] = DATA_REQUEST_SET_I;
  assign irq_ev[`FSR_IRQ_ERR] = |flag_set[4:0];
  assign irq_clr = (wr & hit_stat) ? DAT_I[`FSR_IRQ_W-1:0] : '0;
  assign IRQ_O = |(irq_stat & irq_mask);

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      irq_stat <= '0;
    end
    else
    begin
      irq_stat <= irq_ev | (irq_stat & ~irq_clr);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      irq_mask <= `FSR_MASK_RST;
    end
    else if (wr & hit_mask)
    begin
      irq_mask <= DAT_I[`FSR_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  logic [`FSR_CTRL_W-1:0] ctrl;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ctrl <= `FSR_CTRL_RST;
    end
    else if (wr & hit_ctrl)
    begin
      ctrl <= DAT_I[`FSR_CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  logic [31:0] rdata;

  // unmapped offsets answer with ack and zero data
  always_comb
  begin
    rdata = 32'h00000000;
    if (hit_cond)
      rdata[7:0] = cond;
    else if (hit_cmd)
      rdata[2:0] = cmd_type;
    else if (hit_data)
      rdata[7:0] = DATA_BYTE_O;
    else if (hit_stat)
      rdata[`FSR_IRQ_W-1:0] = irq_stat;
    else if (hit_mask)
      rdata[`FSR_IRQ_W-1:0] = irq_mask;
    else if (hit_ctrl)
      rdata[`FSR_CTRL_W-1:0] = ctrl;
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end
    else
    begin
      ACK_O <= req;
      if (rd)
        DAT_O <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // step output timing
  // ----------------------------------------------------------------
  fsr_step_timer #(
    .CW(12)
  ) u_step (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .req_i(STEP_REQ_I),
    .dir_i(STEP_DIR_I),
    .wide_i(ctrl[`FSR_CTRL_WIDE]),
    .slow_i(ctrl[`FSR_CTRL_SLOW]),
    .step_o(STEP_O),
    .dir_o(DIR_O),
    .busy_o(STEP_BUSY_O)
  );

  // ----------------------------------------------------------------
  // raw read pulse qualification
  // ----------------------------------------------------------------
  logic rr_d;
  logic rr_win;
  logic rr_cross;
  logic [WCW-1:0] rr_len;
  logic [WCW-1:0] span_lim;
  logic rr_ok;

  // limit doubles for the 1 MHz master clock
  assign span_lim = ctrl[`FSR_CTRL_MFM]
    ? WCW'(ctrl[`FSR_CTRL_SLOW] ? 2 * `FSR_SPAN_MFM_CYC : `FSR_SPAN_MFM_CYC)
    : WCW'(ctrl[`FSR_CTRL_SLOW] ? 2 * `FSR_SPAN_FM_CYC : `FSR_SPAN_FM_CYC);
  // a pulse inside one window passes at any width
  assign rr_ok = ~rr_cross | (rr_len < span_lim);

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rr_d <= 1'b0;
      rr_win <= 1'b0;
      rr_cross <= 1'b0;
      rr_len <= '0;
    end
    else
    begin
      rr_d <= RAW_READ_I;
      if (RAW_READ_I & ~rr_d)
      begin
        // window level at the start is only recorded, never required
        rr_win <= READ_WINDOW_I;
        rr_cross <= 1'b0;
        rr_len <= WCW'(1);
      end
      else if (RAW_READ_I)
      begin
        if (READ_WINDOW_I != rr_win)
          rr_cross <= 1'b1;
        if (rr_len != '1)
          rr_len <= rr_len + WCW'(1);
      end
    end
  end

  // judged on the trailing edge, so width is known in full
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      RAW_PULSE_O <= 1'b0;
      RAW_REJECT_O <= 1'b0;
      RAW_WINDOW_O <= 1'b0;
    end
    else
    begin
      RAW_PULSE_O <= ~RAW_READ_I & rr_d & rr_ok;
      RAW_REJECT_O <= ~RAW_READ_I & rr_d & ~rr_ok;
      if (~RAW_READ_I & rr_d)
        RAW_WINDOW_O <= rr_win;
    end
  end

endmodule : fsr_top
`default_nettype wire

// *** tb/fsr_drive_model.sv ***
// drive side model: active-low status pins, head engage delay, raw read pulses
// assumes the bench gives the drive state in active-high terms
`timescale 1ns/1ps
`default_nettype none
module fsr_drive_model #(
  parameter int SETTLE_DLY = 4
) (
  input wire logic clk_i,
  input wire logic wp_i,
  input wire logic tr0_i,
  input wire logic idx_i,
  input wire logic hload_i,
  output logic wp_n_o,
  output logic tr0_n_o,
  output logic idx_n_o,
  output logic htime_o,
  output logic raw_o,
  output logic win_o
);
  logic [7:0] hload_sr;
  assign wp_n_o = !wp_i;
  assign tr0_n_o = !tr0_i;
  assign idx_n_o = !idx_i;
  // the head settles a few cycles after load is asked for
  assign htime_o = hload_sr[SETTLE_DLY-1];
  initial
  begin
    hload_sr = 8'h00;
    raw_o = 1'b0;
    win_o = 1'b0;
  end
  always @(posedge clk_i) hload_sr <= {hload_sr[6:0], hload_i};
  // pulse high for w cycles; the window may flip halfway through
  task automatic raw(input int w, input logic flip);
    int i;
    @(posedge clk_i);
    raw_o <= 1'b1;
    for (i = 1; i < w; i++)
    begin
      @(posedge clk_i);
      if (flip && i == w / 2)
        win_o <= !win_o;
    end
    @(posedge clk_i);
    raw_o <= 1'b0;
  endtask : raw
endmodule : fsr_drive_model
`default_nettype wire

// *** tb/fsr_checker_properties.sv ***
// assertions on the status register bank ports
// assumes it is bound onto fsr_top with one clock and reset high
`timescale 1ns/1ps
`default_nettype none
module fsr_checker (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic MASTER_RESET_IN_I,
  input wire logic READY_I,
  input wire logic WRITE_PROTECT_IN_I,
  input wire logic HEAD_LOAD_OUT_I,
  input wire logic HEAD_LOAD_TIMING_IN_I,
  input wire logic TRACK_ZERO_IN_I,
  input wire logic INDEX_PULSE_IN_I,
  input wire logic DATA_REQUEST_SET_I,
  input wire logic DONE_I,
  input wire logic STEP_REQ_I,
  input wire logic RAW_READ_I,
  input wire logic [2:0] CMD_TYPE_O,
  input wire logic DATA_REQUEST_O,
  input wire logic INTERRUPT_REQUEST_O,
  input wire logic STEP_O,
  input wire logic STEP_BUSY_O,
  input wire logic RAW_PULSE_O,
  input wire logic RAW_REJECT_O
);
  logic [11:0] since_req;
  logic [11:0] hi_cnt;
  // counters, since step delays are far beyond a repetition count
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      since_req <= 12'h000;
    else if (STEP_REQ_I && !STEP_BUSY_O)
      since_req <= 12'h000;
    else if (since_req != 12'hFFF)
      since_req <= since_req + 12'h001;
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      hi_cnt <= 12'h000;
    else
      hi_cnt <= STEP_O ? hi_cnt + 12'h001 : 12'h000;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence cond_rd;
    ACK_O && $past(ADR_I) == 8'h00 && !$past(WE_I);
  endsequence
  sequence type1_rd;
    cond_rd ##0 $past(CMD_TYPE_O) == 3'h0;
  endsequence
  chk_not_ready_bit: assert property (cond_rd |->
    DAT_O[7] == $past(!READY_I || MASTER_RESET_IN_I)) else $error("not ready bit wrong");
  chk_protect_bit: assert property (type1_rd |->
    DAT_O[6] == !$past(WRITE_PROTECT_IN_I)) else $error("protect bit wrong");
  chk_head_loaded: assert property (type1_rd |->
    DAT_O[5] == $past(HEAD_LOAD_OUT_I && HEAD_LOAD_TIMING_IN_I)) else $error("head bit wrong");
  chk_track_zero: assert property (type1_rd |->
    DAT_O[2] == !$past(TRACK_ZERO_IN_I)) else $error("track zero bit wrong");
  chk_index_bit: assert property (type1_rd |->
    DAT_O[1] == !$past(INDEX_PULSE_IN_I)) else $error("index bit wrong");
  chk_track_read_zeros: assert property (cond_rd ##0 $past(CMD_TYPE_O) == 3'h3 |->
    DAT_O[6:3] == 4'h0) else $error("read track zeros wrong");
  chk_addr_read_zeros: assert property (cond_rd ##0 $past(CMD_TYPE_O) == 3'h1 |->
    DAT_O[6:5] == 2'h0) else $error("read address zeros wrong");
  chk_irq_read_clear: assert property (CYC_I && STB_I && !ACK_O && !WE_I && ADR_I == 8'h00
    && !DONE_I |=> !INTERRUPT_REQUEST_O) else $error("status read kept irq");
  chk_data_access_clear: assert property (CYC_I && STB_I && !ACK_O && ADR_I == 8'h08
    && !DATA_REQUEST_SET_I |=> !DATA_REQUEST_O) else $error("data access kept data request");
  chk_step_setup: assert property ($rose(STEP_O) |->
    since_req inside {[599:601], [1199:1201]}) else $error("step setup time wrong");
  chk_step_width: assert property ($fell(STEP_O) |->
    hi_cnt inside {[99:101], [199:201], [399:401]}) else $error("step width wrong");
  chk_raw_verdict: assert property ((RAW_PULSE_O || RAW_REJECT_O) |->
    !(RAW_PULSE_O && RAW_REJECT_O) && !$past(RAW_READ_I) && $past(RAW_READ_I, 2))
    else $error("raw verdict not one cycle after a pulse end");
  cover property (cond_rd);
  cover property ($rose(STEP_O));
  cover property (RAW_REJECT_O);
endmodule : fsr_checker
bind fsr_top fsr_checker chk_u (.*);
`default_nettype wire

// *** tb/test_floppy_status_register.sv ***
// self-checking bench of the floppy status register bank
// assumes the drive model and the bound checker from tb/
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.svh"
module test_floppy_status_register;
  logic clk, rst, cyc, stb, we, mrst, rdy, wp, tr0, idx, hload, sreq, sdir, rwin;
  logic ack, irq, dreq, ireq, step, dir, sbusy, rpls, rrej, wp_n, tr0_n, idx_n, htime, raw, win;
  logic [7:0] adr, ev, dbyte, dbo, x;
  logic [2:0] ctype;
  logic [31:0] wdat, rdat, q;
  logic [7:0] pre [6] = '{8'h41, 8'h01, 8'h01, 8'h01, 8'h41, 8'h41};
  logic [7:0] post [6] = '{8'h59, 8'h1F, 8'h3F, 8'h07, 8'h7F, 8'h67};
  int wid [4] = '{14, 15, 40, 20};
  logic [3:0] flp = 4'b1011;
  int fails, checked, n, e;
  fsr_drive_model drv_u (.clk_i(clk), .wp_i(wp), .tr0_i(tr0), .idx_i(idx), .hload_i(hload),
    .wp_n_o(wp_n), .tr0_n_o(tr0_n), .idx_n_o(idx_n), .htime_o(htime), .raw_o(raw), .win_o(win));
  fsr_top dut_u (.CLOCK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .WE_I(we),
    .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdat), .ACK_O(ack), .IRQ_O(irq),
    .MASTER_RESET_IN_I(mrst), .READY_I(rdy), .WRITE_PROTECT_IN_I(wp_n), .HEAD_LOAD_OUT_I(hload),
    .HEAD_LOAD_TIMING_IN_I(htime), .TRACK_ZERO_IN_I(tr0_n), .INDEX_PULSE_IN_I(idx_n),
    .SEEK_ERR_I(ev[0]), .CRC_ERR_I(ev[1]), .RECORD_NOT_FOUND_I(ev[2]), .LOST_DATA_I(ev[3]),
    .WRITE_FAULT_I(ev[4]), .DELETED_MARK_I(ev[5]), .DATA_REQUEST_SET_I(ev[6]),
    .DATA_BYTE_I(dbyte), .DONE_I(ev[7]), .STEP_REQ_I(sreq), .STEP_DIR_I(sdir),
    .RAW_READ_I(raw), .READ_WINDOW_I(win), .DATA_BYTE_O(dbo), .CMD_TYPE_O(ctype),
    .DATA_REQUEST_O(dreq), .INTERRUPT_REQUEST_O(ireq), .STEP_O(step), .DIR_O(dir),
    .STEP_BUSY_O(sbusy), .RAW_PULSE_O(rpls), .RAW_WINDOW_O(rwin), .RAW_REJECT_O(rrej));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    // no per-call limit: only the watchdog ends a hung wait
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask : pulse
  task automatic complete_run();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial
  begin
    {rst, rdy, cyc, stb, we, mrst, wp, tr0, idx, hload, sreq, sdir} = 12'hC00;
    {adr, ev, dbyte, wdat} = '0;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `FSR_ADR_CMD, 0);
    chk(q, 32'h0);
    wb(1'b0, 8'h40, 0);
    chk(q, 32'h0);
    for (int k = 0; k < 64; k++)
    begin
      {rdy, mrst, wp, tr0, idx, hload} <= k[5:0];
      repeat (6) @(posedge clk);
      wb(1'b0, `FSR_ADR_COND, 0);
      x = {!k[5] || k[4], k[3], k[0], 2'b00, k[2], k[1], 1'b0};
      chk(q, {24'h0, x});
    end
    {rdy, mrst, wp, tr0, idx, hload} <= 6'b101000;
    for (int t = 0; t < 6; t++)
    begin
      dbyte <= 8'hA0 + 8'(t);
      wb(1'b1, `FSR_ADR_CMD, t);
      wb(1'b0, `FSR_ADR_COND, 0);
      chk(q, {24'h0, pre[t]});
      pulse(8'h7F);
      wb(1'b0, `FSR_ADR_COND, 0);
      chk(q, {24'h0, post[t]});
      wb(1'b0, `FSR_ADR_DATA, 0);
      chk(q, 32'hA0 + t);
      chk(dbo, 8'hA0 + 8'(t));
      chk(dreq, 1'b0);
      pulse(8'h80);
      @(posedge clk);
      chk(ireq, 1'b1);
      wb(1'b0, `FSR_ADR_COND, 0);
      chk(q, {24'h0, post[t] & (t == 0 ? 8'hFE : 8'hFC)});
      chk(ireq, 1'b0);
    end
    wb(1'b1, `FSR_ADR_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    wb(1'b1, `FSR_ADR_IRQ_STAT, 32'h7);
    chk(irq, 1'b0);
    wb(1'b0, `FSR_ADR_IRQ_STAT, 0);
    chk(q, 32'h0);
    wb(1'b1, `FSR_ADR_IRQ_MASK, 32'h0);
    pulse(8'h80);
    @(posedge clk);
    chk(irq, 1'b0);
    wb(1'b0, `FSR_ADR_IRQ_STAT, 0);
    chk(q, 32'h1);
    wb(1'b1, `FSR_ADR_CMD, 32'h1);
    wb(1'b0, `FSR_ADR_COND, 0);
    chk(q, 32'h01);
    chk(ireq, 1'b0);
    wb(1'b1, `FSR_ADR_CMD, 32'h6);
    chk(ireq, 1'b1);
    wb(1'b0, `FSR_ADR_COND, 0);
    chk(q, 32'h0);
    wb(1'b1, `FSR_ADR_CMD, 32'h6);
    chk(ctype, 3'h0);
    wb(1'b0, `FSR_ADR_COND, 0);
    chk(q, 32'h40);
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, `FSR_ADR_CTRL, c);
      {sreq, sdir} <= {1'b1, !c[0]};
      @(posedge clk);
      sreq <= 1'b0;
      n = 0;
      while (step !== 1'b1 && n < 3000) @(posedge clk) n++;
      e = `FSR_DIR_CYC * (c[1] ? 2 : 1);
      chk(dir, !c[0]);
      chk(n >= e - 2 && n <= e + 2, 1'b1);
      chk(sbusy, 1'b1);
      n = 0;
      while (step === 1'b1 && n < 3000) @(posedge clk) n++;
      e = (c[0] ? `FSR_STEP_W_CYC : `FSR_STEP_N_CYC) * (c[1] ? 2 : 1);
      chk(n >= e - 2 && n <= e + 2, 1'b1);
      chk(sbusy, 1'b0);
    end
    wb(1'b1, `FSR_ADR_CTRL, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      x[0] = win;
      drv_u.raw(wid[i], flp[i]);
      n = 0;
      while (rpls !== 1'b1 && rrej !== 1'b1 && n < 8) @(posedge clk) n++;
      e = flp[i] && wid[i] >= `FSR_SPAN_MFM_CYC;
      chk({rpls, rrej}, {!e[0], e[0]});
      chk(rwin, x[0]);
    end
    complete_run();
  end
endmodule : test_floppy_status_register
`default_nettype wire
